// ==== src/bsme_pkg.sv ====
// Constants, state type and shared decode helpers for the branch/skip/move executor
//
// How it works
// RULE1 - I/O bit clear: skip next instruction, PC advances 2 or 3, 1/2/3 cycles.
// RULE2 - I/O bit set: skip next instruction, PC advances 2 or 3, 1/2/3 cycles.
// RULE3 - Generic flag-set branch picks flag by index; taken gives PC+k+1, 1/2 cycles.
// RULE4 - Generic flag-clear branch picks flag by index; taken gives PC+k+1, 1/2 cycles.
// RULE5 - Branch equal taken to PC+k+1 exactly when zero flag is one.
// RULE6 - Branch not equal taken to PC+k+1 only when zero flag is zero.
// RULE7 - Carry set and lower branches both taken when carry is one.
// RULE8 - Carry clear and same-or-higher branches both taken when carry is zero.
// RULE9 - Minus branch taken to PC+k+1 when negative flag is one.
// RULE10 - Plus branch taken to PC+k+1 when negative flag is zero.
// RULE11 - Signed greater-or-equal branch taken when negative xor overflow is zero.
// RULE12 - Signed less-than branch taken when negative xor overflow is one.
// RULE13 - Half-carry-set branch taken when half carry is one, 1/2 cycles.
// RULE14 - Half-carry-clear branch taken when half carry is zero, 1/2 cycles.
// RULE15 - Transfer-set branch taken to PC+k+1 when transfer flag is one.
// RULE16 - Transfer-clear branch taken when transfer flag is zero, 1/2 cycles.
// RULE17 - Interrupt-enabled branch taken when global interrupt flag is one, 1/2 cycles.
// RULE18 - Interrupt-disabled branch taken when global interrupt flag is zero, 1/2 cycles.
// RULE19 - Register copy moves source into destination in one cycle, flags untouched.
// RULE20 - Post-increment X load reads byte at X into Rd, X+1, 2 cycles.
// RULE21 - Untaken branch costs 1 cycle, taken 2; offset is signed word displacement.
// RULE22 - Taken skip over one-word instruction costs 2 cycles, two-word costs 3.
// RULE23 - Skips and branches never change any flag_word bit.
package bsme_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PC     = 8'h04;
  localparam logic [7:0] OFF_FLAGS  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_GPR    = 8'h80;

  // Field positions
  localparam int CTRL_RUN_BIT  = 0;
  localparam int ST_BUSY_BIT   = 2;
  localparam int ST_BADOP_BIT  = 1;
  localparam int ST_HALT_BIT   = 0;

  // Reset values
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic        RST_RUN   = 1'b0;

  // Flag positions inside flag_word
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;

  // Pointer register indices
  localparam logic [4:0] X_LO = 5'h1A;
  localparam logic [4:0] X_HI = 5'h1B;

  // Opcode masks and patterns
  localparam logic [15:0] M_BRANCH  = 16'hF800;
  localparam logic [15:0] P_BRANCH  = 16'hF000;
  localparam int          BR_CLR_BIT = 10;
  localparam logic [15:0] M_SKIPIO  = 16'hFD00;
  localparam logic [15:0] P_SKIPIO  = 16'h9900;
  localparam int          SK_SET_BIT = 9;
  localparam logic [15:0] M_COPY    = 16'hFC00;
  localparam logic [15:0] P_COPY    = 16'h2C00;
  localparam logic [15:0] M_FETCHX  = 16'hFE0F;
  localparam logic [15:0] P_FETCHX  = 16'h900D;
  localparam logic [15:0] M_LONGJC  = 16'hFE0C;
  localparam logic [15:0] P_LONGJC  = 16'h940C;
  localparam logic [15:0] M_LONGLS  = 16'hFC0F;
  localparam logic [15:0] P_LONGLS  = 16'h9000;

  // Executor states, one-hot
  typedef enum logic [5:0] {
    ST_HALT  = 6'h01,
    ST_EXEC  = 6'h02,
    ST_BR2   = 6'h04,
    ST_SKIP  = 6'h08,
    ST_SKIP2 = 6'h10,
    ST_LD2   = 6'h20
  } bsme_state_t;

  // Masked opcode compare
  function automatic logic op_match(input logic [15:0] instr, input logic [15:0] mask,
                                    input logic [15:0] pat);
    op_match = ((instr & mask) == pat);
  endfunction : op_match

  // Instructions that carry a second word
  function automatic logic is_two_word(input logic [15:0] instr);
    is_two_word = op_match(instr, M_LONGJC, P_LONGJC) | op_match(instr, M_LONGLS, P_LONGLS);
  endfunction : is_two_word

endpackage : bsme_pkg

// ==== src/bsme_cond.sv ====
// Condition evaluation for flag branches and I/O bit skips
`timescale 1ns/1ps
`default_nettype none
module bsme_cond (
  // Instruction under execution
  input  wire logic [15:0] instr,
  // Flag state and addressed I/O byte
  input  wire logic [7:0]  flag_word,
  input  wire logic [7:0]  io_rdata,
  // Decode results
  output logic             is_branch,
  output logic             branch_take,
  output logic [15:0]      branch_off,
  output logic             is_skip,
  output logic             skip_take
);

  logic [2:0] flag_sel;
  logic       flag_bit;
  logic       io_bit;

  // Flag pick by index; the sign slot is formed from N and V directly
  always_comb begin
    flag_sel = instr[2:0];
    if (flag_sel == bsme_pkg::FLG_S) begin
      flag_bit = flag_word[bsme_pkg::FLG_N] ^ flag_word[bsme_pkg::FLG_V]; // [RULE11] [RULE12]
    end else begin
      flag_bit = flag_word[flag_sel]; // [RULE5] [RULE6] [RULE7] [RULE8] [RULE9] [RULE10]
    end
  end

  // Set form takes on one, clear form on zero
  always_comb begin
    is_branch   = bsme_pkg::op_match(instr, bsme_pkg::M_BRANCH, bsme_pkg::P_BRANCH);
    branch_take = instr[bsme_pkg::BR_CLR_BIT] ? ~flag_bit : flag_bit; // [RULE3] [RULE4]
    branch_off  = {{9{instr[9]}}, instr[9:3]}; // [RULE21]
  end
  // Aliases above cover [RULE13] [RULE14] [RULE15] [RULE16] [RULE17] [RULE18]

  // I/O bit skips
  always_comb begin
    is_skip   = bsme_pkg::op_match(instr, bsme_pkg::M_SKIPIO, bsme_pkg::P_SKIPIO);
    io_bit    = io_rdata[instr[2:0]];
    skip_take = instr[bsme_pkg::SK_SET_BIT] ? io_bit : ~io_bit; // [RULE1] [RULE2]
  end

endmodule : bsme_cond
`default_nettype wire

// ==== src/bsme_exec.sv ====
// Executor for skips, flag branches, register copy and X post-increment load
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module bsme_exec (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Program memory, word addressed, combinational read
  output logic [15:0]      pm_addr,
  input  wire logic [15:0] pm_rdata,
  // I/O space, combinational read
  output logic [4:0]       io_addr,
  input  wire logic [7:0]  io_rdata,
  // Data space, read data valid in the same cycle as dm_re
  output logic [15:0]      dm_addr,
  output logic             dm_re,
  input  wire logic [7:0]  dm_rdata,
  // Instruction completion pulse
  output logic             instr_done
);

  // State
  bsme_pkg::bsme_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic        run_q, run_d;
  logic        badop_q, badop_d;
  logic [7:0]  flags_q, flags_d;
  logic [15:0] dm_addr_q, dm_addr_d;
  logic        dm_re_q, dm_re_d;
  logic [4:0]  ld_dst_q, ld_dst_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0]  rf_q [32];
  logic [7:0]  rf_d [32];

  // Core strobes
  logic        core_we;
  logic [4:0]  core_wa;
  logic [7:0]  core_wd;
  logic        x_inc;
  logic        badop_set;
  logic        done;
  logic [15:0] x_ptr;

  // Decode
  logic        is_branch;
  logic        branch_take;
  logic [15:0] branch_off;
  logic        is_skip;
  logic        skip_take;
  logic        is_copy;
  logic        is_fetchx;

  // APB qualifiers
  logic        apb_setup;
  logic        apb_wr;
  logic        halted;
  logic        hit_gpr;

  // Address decode for the error response; reads use their own compare chain
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == bsme_pkg::OFF_CTRL) | (a == bsme_pkg::OFF_PC) |
                  (a == bsme_pkg::OFF_FLAGS) | (a == bsme_pkg::OFF_STATUS) |
                  (a[7] & (a[1:0] == 2'h0));
  endfunction : addr_mapped

  bsme_cond u_cond (
    .instr       (pm_rdata),
    .flag_word   (flags_q),
    .io_rdata    (io_rdata),
    .is_branch   (is_branch),
    .branch_take (branch_take),
    .branch_off  (branch_off),
    .is_skip     (is_skip),
    .skip_take   (skip_take)
  );

  // Remaining decode and pointer view
  always_comb begin
    is_copy   = bsme_pkg::op_match(pm_rdata, bsme_pkg::M_COPY, bsme_pkg::P_COPY);
    is_fetchx = bsme_pkg::op_match(pm_rdata, bsme_pkg::M_FETCHX, bsme_pkg::P_FETCHX);
    x_ptr     = {rf_q[bsme_pkg::X_HI], rf_q[bsme_pkg::X_LO]};
  end

  // APB phase qualifiers; software edits PC, flags and registers only while halted
  always_comb begin
    apb_setup = psel & ~penable;
    apb_wr    = psel & penable & pwrite;
    halted    = (state_q == bsme_pkg::ST_HALT);
    hit_gpr   = paddr[7] & (paddr[1:0] == 2'h0);
  end

  // Executor sequence
  always_comb begin
    state_d   = state_q;
    pc_d      = pc_q;
    dm_addr_d = dm_addr_q;
    dm_re_d   = 1'b0;
    ld_dst_d  = ld_dst_q;
    core_we   = 1'b0;
    core_wa   = 5'h00;
    core_wd   = 8'h00;
    x_inc     = 1'b0;
    badop_set = 1'b0;
    done      = 1'b0;
    case (state_q)
      bsme_pkg::ST_HALT: begin
        if (run_q) begin
          state_d = bsme_pkg::ST_EXEC;
        end
      end
      bsme_pkg::ST_EXEC: begin
        if (!run_q) begin
          state_d = bsme_pkg::ST_HALT;
        end else if (is_branch) begin
          // Flags are only read here, never written [RULE23]
          if (branch_take) begin
            pc_d    = pc_q + branch_off + 16'h0001; // [RULE3] [RULE4] [RULE21]
            state_d = bsme_pkg::ST_BR2;
          end else begin
            pc_d = pc_q + 16'h0001; // [RULE21]
            done = 1'b1;
          end
        end else if (is_skip) begin
          pc_d = pc_q + 16'h0001;
          if (skip_take) begin
            state_d = bsme_pkg::ST_SKIP; // [RULE1] [RULE2]
          end else begin
            done = 1'b1;
          end
        end else if (is_copy) begin
          core_we = 1'b1; // [RULE19]
          core_wa = pm_rdata[8:4];
          core_wd = rf_q[{pm_rdata[9], pm_rdata[3:0]}];
          pc_d    = pc_q + 16'h0001;
          done    = 1'b1;
        end else if (is_fetchx) begin
          dm_addr_d = x_ptr; // [RULE20]
          dm_re_d   = 1'b1;
          ld_dst_d  = pm_rdata[8:4];
          state_d   = bsme_pkg::ST_LD2;
        end else begin
          // Unknown opcode: stop rather than guess, PC left on it
          badop_set = 1'b1;
          state_d   = bsme_pkg::ST_HALT;
        end
      end
      bsme_pkg::ST_BR2: begin
        done    = 1'b1; // [RULE21]
        state_d = bsme_pkg::ST_EXEC;
      end
      bsme_pkg::ST_SKIP: begin
        // PC now names the skipped word; its length sets the cost
        if (bsme_pkg::is_two_word(pm_rdata)) begin
          pc_d    = pc_q + 16'h0002; // [RULE22]
          state_d = bsme_pkg::ST_SKIP2;
        end else begin
          pc_d    = pc_q + 16'h0001; // [RULE22]
          done    = 1'b1;
          state_d = bsme_pkg::ST_EXEC;
        end
      end
      bsme_pkg::ST_SKIP2: begin
        done    = 1'b1; // [RULE22]
        state_d = bsme_pkg::ST_EXEC;
      end
      bsme_pkg::ST_LD2: begin
        core_we = 1'b1; // [RULE20]
        core_wa = ld_dst_q;
        core_wd = dm_rdata;
        x_inc   = 1'b1;
        pc_d    = pc_q + 16'h0001;
        done    = 1'b1;
        state_d = bsme_pkg::ST_EXEC;
      end
      default: begin
        state_d = bsme_pkg::ST_HALT;
      end
    endcase
    // Software may move the PC only while halted
    if (apb_wr && halted && (paddr == bsme_pkg::OFF_PC)) begin
      pc_d = pwdata[15:0];
    end
  end

  // Control, flags and sticky status; hardware set beats software clear
  always_comb begin
    run_d   = run_q;
    flags_d = flags_q;
    if (apb_wr && (paddr == bsme_pkg::OFF_CTRL)) begin
      run_d = pwdata[bsme_pkg::CTRL_RUN_BIT];
    end
    if (badop_set) begin
      run_d = 1'b0;
    end
    // Flags change only by software, so no core path touches them [RULE23]
    if (apb_wr && halted && (paddr == bsme_pkg::OFF_FLAGS)) begin
      flags_d = pwdata[7:0];
    end
    badop_d = badop_q;
    if (apb_wr && (paddr == bsme_pkg::OFF_STATUS) && pwdata[bsme_pkg::ST_BADOP_BIT]) begin
      badop_d = 1'b0;
    end
    if (badop_set) begin
      badop_d = 1'b1;
    end
  end

  // Register file next value; X increment is applied last, so it wins
  always_comb begin
    rf_d = rf_q;
    if (apb_wr && halted && hit_gpr) begin
      rf_d[paddr[6:2]] = pwdata[7:0];
    end
    if (core_we) begin
      rf_d[core_wa] = core_wd;
    end
    if (x_inc) begin
      {rf_d[bsme_pkg::X_HI], rf_d[bsme_pkg::X_LO]} = x_ptr + 16'h0001; // [RULE20]
    end
  end

  // Read data captured in the setup phase so prdata comes from a flop
  always_comb begin
    prdata_d = prdata_q;
    if (apb_setup) begin
      prdata_d = 32'h0000_0000;
      if (paddr == bsme_pkg::OFF_CTRL) begin
        prdata_d[bsme_pkg::CTRL_RUN_BIT] = run_q;
      end else if (paddr == bsme_pkg::OFF_PC) begin
        prdata_d[15:0] = pc_q;
      end else if (paddr == bsme_pkg::OFF_FLAGS) begin
        prdata_d[7:0] = flags_q;
      end else if (paddr == bsme_pkg::OFF_STATUS) begin
        prdata_d[bsme_pkg::ST_HALT_BIT]  = halted;
        prdata_d[bsme_pkg::ST_BUSY_BIT]  = ~halted;
        prdata_d[bsme_pkg::ST_BADOP_BIT] = badop_q;
      end else if (hit_gpr) begin
        prdata_d[7:0] = rf_q[paddr[6:2]];
      end
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= bsme_pkg::ST_HALT;
      pc_q      <= bsme_pkg::RST_PC;
      run_q     <= bsme_pkg::RST_RUN;
      badop_q   <= 1'b0;
      flags_q   <= bsme_pkg::RST_FLAGS;
      dm_addr_q <= 16'h0000;
      dm_re_q   <= 1'b0;
      ld_dst_q  <= 5'h00;
      prdata_q  <= 32'h0000_0000;
    end else begin
      state_q   <= state_d;
      pc_q      <= pc_d;
      run_q     <= run_d;
      badop_q   <= badop_d;
      flags_q   <= flags_d;
      dm_addr_q <= dm_addr_d;
      dm_re_q   <= dm_re_d;
      ld_dst_q  <= ld_dst_d;
      prdata_q  <= prdata_d;
    end
  end

  // Register file, cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= 8'h00;
      end
    end else begin
      rf_q <= rf_d;
    end
  end

  // Outputs; zero-wait slave, so pready is constant high
  always_comb begin
    prdata     = prdata_q;
    pready     = 1'b1;
    pslverr    = psel & penable & ~addr_mapped(paddr);
    pm_addr    = pc_q;
    io_addr    = pm_rdata[7:3];
    dm_addr    = dm_addr_q;
    dm_re      = dm_re_q;
    instr_done = done;
  end

endmodule : bsme_exec
`default_nettype wire

// ==== tb/bsme_exec_properties.sv ====
// Checker for execution timing and program counter steps of the executor
`timescale 1ns/1ps
`default_nettype none
module bsme_exec_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Execution side
  input wire logic [15:0] pm_addr,
  input wire logic [15:0] pm_rdata,
  input wire logic        dm_re,
  input wire logic        instr_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decode of the word on the fetch port; a cycle after a done is a fresh start
  logic        br, sk, cp, ld, lw, st;
  logic [15:0] tgt;
  assign br  = (pm_rdata & bsme_pkg::M_BRANCH) == bsme_pkg::P_BRANCH;
  assign sk  = (pm_rdata & bsme_pkg::M_SKIPIO) == bsme_pkg::P_SKIPIO;
  assign cp  = (pm_rdata & bsme_pkg::M_COPY) == bsme_pkg::P_COPY;
  assign ld  = (pm_rdata & bsme_pkg::M_FETCHX) == bsme_pkg::P_FETCHX;
  assign lw  = ((pm_rdata & bsme_pkg::M_LONGJC) == bsme_pkg::P_LONGJC) ||
               ((pm_rdata & bsme_pkg::M_LONGLS) == bsme_pkg::P_LONGLS);
  assign tgt = pm_addr + {{9{pm_rdata[9]}}, pm_rdata[9:3]} + 16'h0001;
  // Start cycle; the first instruction of a run is not seen, a known blind spot
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) st <= 1'b0;
    else st <= instr_done;
  AST_BR_NOT: assert property (st && instr_done && (br || sk)
    |=> pm_addr == $past(pm_addr) + 16'h0001) else $error("untaken step wrong");
  AST_BR_TAKEN: assert property (st && !instr_done && br
    |=> instr_done && pm_addr == $past(tgt)) else $error("taken branch target wrong");
  AST_SK_TAKEN: assert property (st && !instr_done && sk
    |=> pm_addr == $past(pm_addr) + 16'h0001 && instr_done == !lw)
    else $error("skip first step wrong");
  AST_SK_LONG: assert property (st && !instr_done && sk ##1 lw
    |=> instr_done && pm_addr == $past(pm_addr, 2) + 16'h0003)
    else $error("long skip wrong");
  AST_CP_ONE: assert property (st && cp |-> instr_done)
    else $error("copy not single cycle");
  AST_LD_TWO: assert property (st && ld |-> !instr_done ##1 (dm_re && instr_done))
    else $error("load not two cycles");
  AST_RE_PC: assert property (dm_re |-> $stable(pm_addr) ##1
    pm_addr == $past(pm_addr) + 16'h0001) else $error("load pc step wrong");
  AST_RE_ONE: assert property (dm_re |=> !dm_re)
    else $error("read strobe too long");
  // Main scenarios
  COV_BR: cover property (st && !instr_done && br);
  COV_SK: cover property (st && !instr_done && sk ##1 lw);
  COV_LD: cover property (dm_re);
endmodule : bsme_exec_props
bind bsme_exec bsme_exec_props u_props (.pclk(pclk), .presetn(presetn), .pm_addr(pm_addr),
  .pm_rdata(pm_rdata), .dm_re(dm_re), .instr_done(instr_done));
`default_nettype wire

// ==== tb/bsme_mem_model.sv ====
// Program, I/O and data memories beside the executor
`timescale 1ns/1ps
`default_nettype none
module bsme_mem_model (
  // Program memory
  input wire logic [15:0] pm_addr,
  output logic     [15:0] pm_rdata,
  // I/O space
  input wire logic [4:0]  io_addr,
  output logic     [7:0]  io_rdata,
  // Data space
  input wire logic [15:0] dm_addr,
  input wire logic        dm_re,
  output logic     [7:0]  dm_rdata
);
  logic [15:0] pm [256];
  logic [7:0]  io [32];
  logic [7:0]  dm [256];
  // Unwritten program words decode as an unknown opcode
  initial foreach (pm[i]) pm[i] = 16'hFFFF;
  // Combinational reads; data line shows the inverse outside the read cycle
  assign pm_rdata = pm[pm_addr[7:0]];
  assign io_rdata = io[io_addr];
  assign dm_rdata = dm_re ? dm[dm_addr[7:0]] : ~dm[dm_addr[7:0]];
endmodule : bsme_mem_model
`default_nettype wire

// ==== tb/branch_skip_and_move_exec_bench.sv ====
// Self-checking bench for the branch, skip, copy and load executor
`timescale 1ns/1ps
`default_nettype none
module branch_skip_and_move_exec_bench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, io_rdata, dm_rdata, cyc = 8'h00, fl;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000DB28;
  logic        pready, pslverr, dm_re, instr_done, first;
  logic [15:0] pm_addr, pm_rdata, dm_addr, pg;
  logic [4:0]  io_addr;
  logic [32:0] rq[$];
  logic [23:0] iq[$];
  int          num_errors = 0, checks_done = 0;
  always #4 pclk = ~pclk;
  bsme_exec u_bsme_exec (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .io_addr(io_addr),
    .io_rdata(io_rdata), .dm_addr(dm_addr), .dm_re(dm_re), .dm_rdata(dm_rdata),
    .instr_done(instr_done));
  bsme_mem_model u_bsme_mem_model (.pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .io_addr(io_addr), .io_rdata(io_rdata), .dm_addr(dm_addr), .dm_re(dm_re),
    .dm_rdata(dm_rdata));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic results();
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic chk_rd(input logic [32:0] g, input logic [32:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_rd
  task automatic chk_ins(input logic [23:0] g, input logic [23:0] e);
    chk_rd({9'h000, g}, {9'h000, e});
  endtask : chk_ins
  // APB master: setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      results();
    end
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic put(input logic [15:0] w);
    u_bsme_mem_model.pm[pg[7:0]] = w;
    pg = pg + 16'h0001;
  endtask : put
  // Expected length and next address; the run's first length is unknown
  task automatic ex(input logic [7:0] d, input logic [15:0] n);
    iq.push_back({first ? 8'h00 : d, n});
    first = 1'b0;
  endtask : ex
  // Read results come back in request order
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1) chk_rd({pslverr, prdata}, rq.pop_front());
  // Each completed instruction: cycles taken and address that follows
  // Done is combinational, so it is looked at mid-cycle, away from the edge
  always @(negedge pclk) begin : mon_ins
    logic [23:0] e;
    if (instr_done === 1'b1) begin
      @(posedge pclk);
      #1;
      e = iq.pop_front();
      chk_ins({(e[23:16] == 8'h00) ? 8'h00 : cyc + 8'h01, pm_addr}, e);
      cyc = 8'h00;
    end else cyc = cyc + 8'h01;
  end
  initial begin
    logic [15:0] b, p, x;
    logic [7:0]  a, r;
    logic        t, s1;
    int          n;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h0);
    rd(8'h0C, 33'h1);
    rd(8'h10, 33'h100000000);
    rd(8'h81, 33'h100000000);
    for (int k = 0; k < 2; k++) begin
      fl = 8'(xs());
      apb(1'b1, 8'h08, {24'h0, fl});
      for (int i = 0; i < 256; i++) u_bsme_mem_model.dm[i] = 8'(xs());
      for (int i = 0; i < 32; i++) u_bsme_mem_model.io[i] = 8'(xs());
      pg = 16'h0000;
      first = 1'b1;
      // Every flag index in both senses, a filler word after each
      for (int s = 0; s < 8; s++) for (int c = 0; c < 2; c++) begin
        t = ((s == 4) ? fl[2] ^ fl[3] : fl[s]) ^ c[0];
        put({5'h1E, c[0], 7'h01, s[2:0]});
        put(16'h2C00);
        if (t) ex(8'h02, pg);
        else begin
          ex(8'h01, pg - 16'h0001);
          ex(8'h01, pg);
        end
      end
      // Forward and backward displacements on the carry flag
      b = {5'h1E, ~fl[0], 10'h000};
      p = pg;
      put(b | 16'h0010);
      put(16'h2C00);
      put(b | 16'h0008);
      put(b | 16'h03E8);
      ex(8'h02, p + 16'h0003);
      ex(8'h02, p + 16'h0001);
      ex(8'h01, p + 16'h0002);
      ex(8'h02, p + 16'h0004);
      // Skips in both senses, one over a two-word instruction
      for (int j = 0; j < 3; j++) begin
        a = 8'(xs());
        t = u_bsme_mem_model.io[a[4:0]][a[7:5]];
        s1 = (j == 2) ? t : j[0];
        put({6'h26, s1, 1'b1, a[4:0], a[7:5]});
        if (j == 2) begin
          put(16'h940C);
          put(16'h0000);
          ex(8'h03, pg);
        end else begin
          put(16'h2C00);
          if (t == s1) ex(8'h02, pg);
          else begin
            ex(8'h01, pg - 16'h0001);
            ex(8'h01, pg);
          end
        end
      end
      // Copy r17 to r9, load r5 via X, then load into the X low byte
      r = 8'(xs());
      x = {8'h00, 8'(xs())};
      apb(1'b1, 8'hC4, {24'h0, r});
      apb(1'b1, 8'hE8, {16'h0, x});
      apb(1'b1, 8'hEC, 32'h0);
      put(16'h2E91);
      ex(8'h01, pg);
      put(16'h905D);
      ex(8'h02, pg);
      put(16'h91AD);
      ex(8'h02, pg);
      put(16'hFFFF);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      n = 0;
      while (iq.size() != 0 && n < 500) begin
        @(posedge pclk);
        n++;
      end
      if (n >= 500) begin
        num_errors++;
        results();
      end
      repeat (3) @(posedge pclk);
      rd(8'h0C, 33'h3);
      apb(1'b1, 8'h0C, 32'h2);
      rd(8'h0C, 33'h1);
      rd(8'h04, {17'h0, pg - 16'h0001});
      rd(8'h08, {25'h0, fl});
      rd(8'hA4, {25'h0, r});
      rd(8'h94, {25'h0, u_bsme_mem_model.dm[x[7:0]]});
      x = x + 16'h0002;
      rd(8'hE8, {25'h0, x[7:0]});
      rd(8'hEC, {25'h0, x[15:8]});
    end
    results();
  end
endmodule : branch_skip_and_move_exec_bench
`default_nettype wire
